// file: rtl/ulr_pkg.sv
// Overview of operation
// - link waits for direction low before command
// - bits 7:6 select idle, transmit, write, read
// - transmit low bits carry optional packet identifier
// - write command low bits are immediate address
// - address 2Fh means extended, address follows
// - read command low bits are immediate address
// - next accepts command, link drives data after
// - link ends write with idle and stop
// - write committed after stop de-asserts
// - link keeps idle 00h after write
// - direction stays low during register write
// - extended write sends address then data
// - read decoded, direction up, next down together
// - transceiver drives value one cycle, drops direction
// - link samples value, then drives idle
// - extended read captures address, then returns value
// - link never drives bus in turnaround cycle; phy outputs idle 00h when direction rises
// - stop lasts exactly one cycle
// - direction high while not ready for commands
package ulr_pkg;
    localparam logic [1:0] ULR_CMD_IDLE   = 2'h0;
    localparam logic [1:0] ULR_CMD_TX     = 2'h1;
    localparam logic [1:0] ULR_CMD_WRITE  = 2'h2;
    localparam logic [1:0] ULR_CMD_READ   = 2'h3;
    localparam logic [5:0] ULR_EXT_ADDR   = 6'h2f;
    localparam logic [7:0] ULR_IDLE_BYTE  = 8'h00;
    localparam int         ULR_TYPE_MSB   = 7;
    localparam int         ULR_TYPE_LSB   = 6;
    localparam logic [7:0] ULR_REG_RESET  = 8'h00;
    localparam logic [3:0] ULR_START_CYC  = 4'h8;
endpackage : ulr_pkg

// file: rtl/ulr_bus_if.sv
`timescale 1ns/1ns
interface ulr_bus_if;
    logic [7:0] phy_data_o;
    logic [7:0] link_data_o;
    logic       link_data_oe;
    logic       dir;
    logic       nxt;
    logic       stp;
    logic [7:0] data;
    // resolved bus level: link drives only while direction is low
    assign data = dir ? phy_data_o : (link_data_oe ? link_data_o : 8'h00);
    modport phy  (output phy_data_o, output dir, output nxt,
                  input data, input stp);
    modport link (output link_data_o, output link_data_oe, output stp,
                  input data, input dir, input nxt);
endinterface : ulr_bus_if

// file: rtl/ulr_phy.sv
`timescale 1ns/1ns
module ulr_phy
    import ulr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    ulr_bus_if.phy          bus,
    output logic [7:0]      tx_pid,
    output logic            tx_start,
    output logic            tx_nopid
);
    // ------------------------------------------------------------
    // register array and state
    // ------------------------------------------------------------
    typedef enum {S_START, S_IDLE, S_ACK, S_EXTADDR, S_WDATA, S_WSTOP,
                  S_RTURN, S_RDRIVE, S_RBACK} ulr_state_t;
    ulr_state_t   state_reg;
    logic [7:0]   regs_reg [256];
    logic [7:0]   addr_reg;
    logic [7:0]   wdata_reg;
    logic         is_read_reg;
    logic         is_ext_reg;
    logic [3:0]   start_reg;
    logic [7:0]   rdata_reg;
    logic [1:0]   ctype;
    assign ctype = bus.data[ULR_TYPE_MSB:ULR_TYPE_LSB];

    // ------------------------------------------------------------
    // protocol sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg   <= S_START;
            start_reg   <= 4'h0;
            addr_reg    <= 8'h00;
            wdata_reg   <= 8'h00;
            is_read_reg <= 1'b0;
            is_ext_reg  <= 1'b0;
        end else if (clk_en) begin
            unique case (state_reg)
                S_START: begin
                    start_reg <= start_reg + 4'h1;
                    if (start_reg == ULR_START_CYC) state_reg <= S_RBACK;
                end
                S_IDLE: begin
                    // zero byte is idle, no operation started
                    if (bus.data != ULR_IDLE_BYTE &&
                        ctype[1]) begin
                        is_read_reg <= ctype == ULR_CMD_READ;
                        is_ext_reg  <= bus.data[5:0] == ULR_EXT_ADDR;
                        addr_reg    <= {2'h0, bus.data[5:0]};
                        state_reg   <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (is_ext_reg) state_reg <= S_EXTADDR;
                    else if (is_read_reg) state_reg <= S_RTURN;
                    else state_reg <= S_WDATA;
                end
                S_EXTADDR: begin
                    addr_reg  <= bus.data;
                    state_reg <= is_read_reg ? S_RTURN : S_WDATA;
                end
                S_WDATA: begin
                    wdata_reg <= bus.data;
                    state_reg <= S_WSTOP;
                end
                S_WSTOP: begin
                    if (!bus.stp) state_reg <= S_IDLE;
                end
                S_RTURN:  state_reg <= S_RDRIVE;
                S_RDRIVE: state_reg <= S_RBACK;
                S_RBACK:  state_reg <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register storage; stop release commits the write
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 256; i++) regs_reg[i] <= ULR_REG_RESET;
        end else if (clk_en && state_reg == S_WSTOP && !bus.stp) begin
            regs_reg[addr_reg] <= wdata_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) rdata_reg <= 8'h00;
        else if (clk_en && state_reg == S_RTURN)
            rdata_reg <= regs_reg[addr_reg];
    end

    // ------------------------------------------------------------
    // transmit command decode, datapath not built here
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_pid   <= 8'h00;
            tx_start <= 1'b0;
            tx_nopid <= 1'b0;
        end else if (clk_en) begin
            tx_start <= state_reg == S_IDLE && ctype == ULR_CMD_TX;
            if (state_reg == S_IDLE && ctype == ULR_CMD_TX) begin
                tx_pid   <= {4'h0, bus.data[3:0]};
                tx_nopid <= bus.data[5:0] == 6'h00;
            end
        end
    end

    // write keeps direction low; read raises it with next falling
    assign bus.dir = state_reg == S_START || state_reg == S_RTURN ||
                     state_reg == S_RDRIVE;
    assign bus.nxt = state_reg == S_ACK || state_reg == S_EXTADDR ||
                     state_reg == S_WDATA;
    assign bus.phy_data_o = state_reg == S_RDRIVE ? rdata_reg
                                                  : ULR_IDLE_BYTE;
endmodule : ulr_phy

// file: rtl/ulr_link.sv
`timescale 1ns/1ns
module ulr_link
    import ulr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    ulr_bus_if.link         bus,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic       req_read,
    input  wire logic [7:0] req_addr,
    input  wire logic [7:0] req_wdata,
    output logic [7:0]      rsp_rdata,
    output logic            rsp_valid
);
    // ------------------------------------------------------------
    // link sequencer
    // ------------------------------------------------------------
    typedef enum {L_IDLE, L_CMD, L_ADDR, L_DATA, L_STOP, L_WAITDIR,
                  L_SAMPLE, L_BACK} ulr_lstate_t;
    ulr_lstate_t  state_reg;
    logic         ext_reg;
    logic         dir_reg;
    logic         read_reg;
    logic [7:0]   addr_reg;
    logic [7:0]   wdata_reg;
    logic [7:0]   out_reg;
    logic         ext;
    assign ext = req_addr > 8'h2e;
    // ready only with bus owned, so commands never collide
    assign req_ready = state_reg == L_IDLE && !bus.dir;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= L_IDLE;
            ext_reg   <= 1'b0;
            read_reg  <= 1'b0;
            addr_reg  <= 8'h00;
            wdata_reg <= 8'h00;
            out_reg   <= ULR_IDLE_BYTE;
            rsp_rdata <= 8'h00;
            rsp_valid <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            unique case (state_reg)
                L_IDLE: begin
                    out_reg <= ULR_IDLE_BYTE;
                    if (req_valid && req_ready) begin
                        ext_reg   <= ext;
                        read_reg  <= req_read;
                        addr_reg  <= req_addr;
                        wdata_reg <= req_wdata;
                        out_reg   <= {req_read ? ULR_CMD_READ
                                               : ULR_CMD_WRITE,
                                      ext ? ULR_EXT_ADDR
                                          : req_addr[5:0]};
                        state_reg <= L_CMD;
                    end
                end
                L_CMD: if (bus.nxt) begin
                    if (ext_reg) begin
                        out_reg   <= addr_reg;
                        state_reg <= L_ADDR;
                    end else if (read_reg) begin
                        state_reg <= L_WAITDIR;
                    end else begin
                        out_reg   <= wdata_reg;
                        state_reg <= L_DATA;
                    end
                end
                L_ADDR: begin
                    if (read_reg) state_reg <= L_WAITDIR;
                    else begin
                        out_reg   <= wdata_reg;
                        state_reg <= L_DATA;
                    end
                end
                L_DATA: begin
                    out_reg   <= ULR_IDLE_BYTE;
                    state_reg <= L_STOP;
                end
                L_STOP:    state_reg <= L_IDLE;
                // value stands the cycle after turnaround; sample it then
                L_WAITDIR: if (bus.dir) state_reg <= L_SAMPLE;
                L_SAMPLE: begin
                    rsp_rdata <= bus.data;
                    rsp_valid <= 1'b1;
                    state_reg <= L_BACK;
                end
                L_BACK: begin
                    out_reg   <= ULR_IDLE_BYTE;
                    state_reg <= L_IDLE;
                end
            endcase
        end
    end

    // last cycle's direction marks turnaround; reset high like the phy
    always_ff @(posedge clk) begin
        if (sys_rst) dir_reg <= 1'b1;
        else if (clk_en) dir_reg <= bus.dir;
    end

    assign bus.stp          = state_reg == L_STOP;
    assign bus.link_data_o  = out_reg;
    // release bus whenever direction is high or turning
    assign bus.link_data_oe = !bus.dir && !dir_reg &&
                              state_reg != L_BACK &&
                              state_reg != L_WAITDIR;
endmodule : ulr_link

// file: verification/ulr_assertions.sv
`timescale 1ns/1ns
module ulr_assertions
    import ulr_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] data,
    input wire logic       dir,
    input wire logic       nxt,
    input wire logic       stp,
    input wire logic       link_data_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // bus rules
    // ------------------------------------------------------------
    stp_pulse_a: assert property (stp |=> !stp)
        else $error("stop held longer than one cycle");
    turn_silent_a: assert property (
        (dir || $fell(dir)) |-> !link_data_oe)
        else $error("link drives bus while phy owns it or in turnaround");
    // past nxt excluded: data bytes after an accept are not commands
    cmd_ack_a: assert property (
        !dir && !nxt && data[7] && !$past(nxt) &&
        $past(data) == ULR_IDLE_BYTE |=> nxt)
        else $error("command not accepted the next cycle");
    read_turn_a: assert property (
        $rose(dir) |-> !nxt ##1 (dir && !nxt) ##1 !dir)
        else $error("read turnaround shape wrong");
    write_dir_low_a: assert property (
        $rose(nxt) && $past(data[7:6]) == ULR_CMD_WRITE |-> !dir [*4])
        else $error("direction rose during register write");
    write_stop_a: assert property (
        $fell(nxt) && !dir && $past(nxt, 2) |->
        stp && data == ULR_IDLE_BYTE ##1 !stp)
        else $error("write not closed by idle and stop");
    idle_quiet_a: assert property (
        !dir && data == ULR_IDLE_BYTE && $past(data) == ULR_IDLE_BYTE &&
        !$past(nxt) |=> !nxt)
        else $error("idle bus started an operation");
    startup_hold_a: assert property ($fell(sys_rst) |-> dir [*8])
        else $error("direction not held high after reset");
    cover property ($rose(nxt) && $past(data[7:6]) == ULR_CMD_WRITE);
    cover property ($rose(dir));
    cover property (!dir && data == 8'hef);
endmodule : ulr_assertions

// file: verification/ulpi_register_access_bench.sv
`timescale 1ns/1ns
module ulpi_register_access_bench
    import ulr_pkg::*;
;
    logic       clk;
    logic       sys_rst;
    logic       req_valid;
    logic       req_ready;
    logic       req_read;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic [7:0] rsp_rdata;
    logic       rsp_valid;
    logic       clk_en;
    logic [7:0] tx_pid;
    logic       tx_start;
    logic       tx_nopid;
    int         tx_seen = 0;
    int         bad_count;
    int         tests_run;
    logic [7:0] adr_tab [5] = '{8'h00, 8'h2e, 8'h2f, 8'h80, 8'hff};

    ulr_bus_if bus ();
    ulr_phy i_ulr_phy (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus(bus), .tx_pid(tx_pid), .tx_start(tx_start),
        .tx_nopid(tx_nopid));
    ulr_link i_ulr_link (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus(bus), .req_valid(req_valid), .req_ready(req_ready),
        .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid));
    ulr_assertions i_ulr_assertions (.clk(clk), .sys_rst(sys_rst),
        .data(bus.data), .dir(bus.dir), .nxt(bus.nxt), .stp(bus.stp),
        .link_data_oe(bus.link_data_oe));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // counts any transmit decode outside reset, unknowns included
    always @(negedge clk) begin
        if (!sys_rst && tx_start !== 1'b0) tx_seen++;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 100) begin
                chk(8'h00, 8'h01);
                close_out();
            end
        end
    endtask : wait_ready

    // called at a falling edge; expected latency counts from command cycle
    task automatic access(input logic rd, input logic [7:0] adr,
                          input logic [7:0] wd, input logic [7:0] exp);
        int n;
        logic [7:0] cmd;
        cmd = {rd ? ULR_CMD_READ : ULR_CMD_WRITE,
               adr < 8'h2f ? adr[5:0] : ULR_EXT_ADDR};
        wait_ready();
        req_valid = 1'b1;
        req_read = rd;
        req_addr = adr;
        req_wdata = wd;
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        chk(bus.data, cmd);
        if (rd) begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
            end
            chk(8'(n), adr < 8'h2f ? 8'h04 : 8'h05);
            chk(rsp_rdata, exp);
            if (n == 20) close_out();
        end
    endtask : access
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        bad_count = 0;
        tests_run = 0;
        clk_en = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        chk({6'h00, bus.dir, req_ready}, 8'h02);
        foreach (adr_tab[i]) begin
            access(1'b1, adr_tab[i], 8'h00, ULR_REG_RESET);
        end
        foreach (adr_tab[i]) begin
            access(1'b0, adr_tab[i], adr_tab[i] ^ 8'h5a, 8'h00);
            access(1'b1, adr_tab[i], 8'h00, adr_tab[i] ^ 8'h5a);
        end
        // boundary below the escape must not alias the escape address
        access(1'b0, 8'h2e, 8'hff, 8'h00);
        access(1'b1, 8'h2f, 8'h00, 8'h2f ^ 8'h5a);
        access(1'b1, 8'h2e, 8'h00, 8'hff);
        // reset in mid-write: transfer must be dropped cleanly
        wait_ready();
        req_valid = 1'b1;
        req_read = 1'b0;
        req_addr = 8'h80;
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        clk_en = 1'b0;
        chk({6'h00, bus.dir, req_ready}, 8'h02);
        // frozen startup must keep the bus past its normal hold time
        repeat (12) @(negedge clk);
        chk({6'h00, bus.dir, req_ready}, 8'h02);
        clk_en = 1'b1;
        access(1'b1, 8'h80, 8'h00, ULR_REG_RESET);
        // register traffic must never decode as a transmit command
        chk({7'(tx_seen), tx_nopid}, 8'h00);
        chk(tx_pid, 8'h00);
        close_out();
    end
endmodule : ulpi_register_access_bench
